/* File: design/wdk_bcd_down.sv */
`default_nettype none

module wdk_bcd_down #(
  parameter int unsigned DIGITS = 4
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Period and control
  input  wire logic [4*DIGITS-1:0]   period,
  input  wire logic                  load,
  input  wire logic                  tick,
  // Status
  output logic                       expire
);

  logic [4*DIGITS-1:0] count;
  logic [4*DIGITS-1:0] next_count;
  logic [DIGITS:0]     borrow;
  logic                period_nz;
  logic                at_one;

  assign borrow[0] = 1'b1;
  assign period_nz = (period != '0);
  assign at_one    = (count == {{(4*DIGITS-4){1'b0}}, 4'h1}) || (count == '0);

  // ----------------------------------------
  // Per-digit BCD decrement
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_digit
      logic [3:0] d;
      assign d = count[4*g +: 4];
      assign borrow[g+1] = borrow[g] && (d == 4'h0);
      assign next_count[4*g +: 4] = !borrow[g] ? d : ((d == 4'h0) ? 4'h9 : d - 4'h1);
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count  <= '0;
      expire <= 1'b0;
    end else if (load || !period_nz) begin
      count  <= period;
      expire <= 1'b0;
    end else if (tick && at_one) begin
      count  <= period;
      expire <= 1'b1;
    end else if (tick) begin
      count  <= next_count;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
    end
  end

endmodule : wdk_bcd_down

`default_nettype wire

/* File: design/wdk_defines.svh */
`ifndef WDK_DEFINES_SVH
`define WDK_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define WDK_OFF_MONTH     5'h05
`define WDK_OFF_DOG_LO    5'h0c
`define WDK_OFF_DOG_HI    5'h0d
`define WDK_OFF_CTRL_A    5'h0e
`define WDK_OFF_CTRL_B    5'h0f

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WDK_BIT_OSC_STOP  7
`define WDK_BIT_PRS       5
`define WDK_BIT_PAB       4
`define WDK_BIT_TDF       3
`define WDK_BIT_KSF       2
`define WDK_BIT_WDF       1
`define WDK_BIT_IRQ_REQUEST_FLAG      0
`define WDK_BIT_TE        7
`define WDK_BIT_TPE       4
`define WDK_BIT_TIE       3
`define WDK_BIT_KIE       2
`define WDK_BIT_WDE       1
`define WDK_BIT_WDS       0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WDK_CTRL_B_RST    8'h00
`define WDK_PERIOD_RST    8'h00
`define WDK_PAB_RST       1'b0
`define WDK_PRS_RST       1'b0
`define WDK_BUS_SYNC_RST  16'he000

// ----------------------------------------
// Timing
// ----------------------------------------
`define WDK_CLK_KHZ       25000
`define WDK_DOG_TICK_US   10000
`define WDK_RST_PULSE_NS  1000
`define WDK_KICK_MIN_NS   200

`endif

/* File: design/wdk_pkg.sv */
`default_nettype none

package wdk_pkg;

  // Reset pulse sequencer
  typedef enum logic [1:0] {
    WDK_PULSE_IDLE = 2'b01,
    WDK_PULSE_LOW  = 2'b10
  } wdk_pulse_state_t;

endpackage : wdk_pkg

`default_nettype wire

/* File: design/wdk_tick_div.sv */
`default_nettype none

module wdk_tick_div #(
  parameter int unsigned CYC = 250000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Control
  input  wire logic run,
  input  wire logic restart,
  // Tick
  output logic      tick
);

  localparam int unsigned CW = $clog2(CYC + 1);

  logic [CW-1:0] count;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (restart) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (run) begin
      if (count == CW'(CYC - 1)) begin
        count <= '0;
        tick  <= 1'b1;
      end else begin
        count <= count + CW'(1);
        tick  <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end

endmodule : wdk_tick_div

`default_nettype wire

/* File: design/wdk_watchdog_wakeup.sv */
// Behaviour
// - Alarm flag with alarm enable sets interrupt request; never without enable.
// - Supply absent, kick enable: kick pulse sets flag, power request low; IRQ later.
// - Supply present, kick enable: kick flag drives IRQ and power request low.
// - Watchdog enable arms timeout output; steering picks interrupt or reset pin.
// - Steering 0 pulls interrupt low; steering 1 gives one reset low pulse.
// - Reset clears watchdog enable and steering bits.
// - Oscillator stop bit halts oscillator while 1; writable any time.
// - Period is four BCD digits in two registers, 10 ms steps.
// - On expiry the counter reloads the period and continues.
// - Nonzero period: every timeout sets timeout flag regardless of enable.
// - Repetitive mode: timeout sets flag, request flag and interrupt output.
// - Writing a period register reloads the counter; host must keep writing.
// - Reading the flag register clears pending interrupt flags.
// - Single-shot: reset pulse for pulse time, then enable clears.
// - Both period registers zero: watchdog disabled, no timeouts.
// - Period registers have no promised power-up value; host loads them.
// - Wakeup works only with wake power enable and transfer enable set.
// - Wakeup, supply absent: alarm match drives power request, sets alarm flag.
// - Aux battery, kick enable, supply low: long enough kick low pulse requests power, sets flag.
// - Wakeup and kick need running oscillator and auxiliary battery.
// - Request flag is OR of all enabled pending sources.
// - Power release clears on alarm with wake enable, or kick flag with kick enable.
// - Writing 0 to timeout flag clears it.
`include "wdk_defines.svh"

`default_nettype none

module wdk_watchdog_wakeup #(
  parameter int unsigned TICK_CYC  = (`WDK_DOG_TICK_US * `WDK_CLK_KHZ) / 1000,
  parameter int unsigned RST_CYC   = (`WDK_RST_PULSE_NS * `WDK_CLK_KHZ + 999999) / 1000000,
  parameter int unsigned KICK_CYC  = (`WDK_KICK_MIN_NS * `WDK_CLK_KHZ + 999999) / 1000000
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Byte-wide register port
  input  wire logic       bus_cs_b,
  input  wire logic       bus_oe_b,
  input  wire logic       bus_we_b,
  input  wire logic [4:0] bus_addr,
  input  wire logic [7:0] bus_data_in,
  output logic      [7:0] bus_data_out,
  output logic            bus_data_oe_b,
  // Supply and kick pins
  input  wire logic       system_supply,
  input  wire logic       aux_battery,
  input  wire logic       kick_input_n,
  // Alarm match from calendar, one-cycle pulse
  input  wire logic       alarm_hit,
  // Outputs
  output logic            irq_n,
  output logic            rst_out_n,
  output logic            power_on_request_n,
  output logic            power_on_request_oe_b,
  output logic            osc_run
);

  localparam int unsigned RW = (RST_CYC  < 2) ? 2 : $clog2(RST_CYC + 1);
  localparam int unsigned KW = (KICK_CYC < 2) ? 2 : $clog2(KICK_CYC + 1);
  localparam int unsigned RC = (RST_CYC  < 1) ? 1 : RST_CYC;
  localparam int unsigned KC = (KICK_CYC < 1) ? 1 : KICK_CYC;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [15:0] bus_s1;
  logic [15:0] bus_s2;
  logic [2:0]  pin_s1;
  logic [2:0]  pin_s2;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_s1 <= `WDK_BUS_SYNC_RST;
      bus_s2 <= `WDK_BUS_SYNC_RST;
      pin_s1 <= 3'h4;
      pin_s2 <= 3'h4;
    end else begin
      bus_s1 <= {bus_cs_b, bus_oe_b, bus_we_b, bus_addr, bus_data_in};
      bus_s2 <= bus_s1;
      pin_s1 <= {kick_input_n, aux_battery, system_supply};
      pin_s2 <= pin_s1;
    end
  end

  logic       cs_s;
  logic       oe_s;
  logic       we_s;
  logic [4:0] addr_s;
  logic [7:0] data_s;
  logic       kick_s;
  logic       aux_s;
  logic       supply_s;

  assign {cs_s, oe_s, we_s, addr_s, data_s} = bus_s2;
  assign {kick_s, aux_s, supply_s}          = pin_s2;

  // ----------------------------------------
  // Access strobes
  // ----------------------------------------
  logic       rd_act;
  logic       wr_act;
  logic       rd_act_q;
  logic       wr_act_q;
  logic [4:0] addr_q;
  logic [7:0] data_q;
  logic       supply_q;

  assign rd_act = !cs_s && !oe_s;
  assign wr_act = !cs_s && !we_s && oe_s;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      addr_q   <= 5'h00;
      data_q   <= 8'h00;
      supply_q <= 1'b0;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      addr_q   <= addr_s;
      supply_q <= supply_s;
      if (wr_act) begin
        data_q <= data_s;
      end
    end
  end

  // Write is taken as the strobe ends, so the data has settled
  logic wr_take;
  logic wr_lo;
  logic wr_hi;
  logic wr_a;
  logic wr_b;
  logic wr_m;
  logic rd_clr;

  assign wr_take = wr_act_q && !wr_act;
  assign wr_lo   = wr_take && (addr_q == `WDK_OFF_DOG_LO);
  assign wr_hi   = wr_take && (addr_q == `WDK_OFF_DOG_HI);
  assign wr_a    = wr_take && (addr_q == `WDK_OFF_CTRL_A);
  assign wr_b    = wr_take && (addr_q == `WDK_OFF_CTRL_B);
  assign wr_m    = wr_take && (addr_q == `WDK_OFF_MONTH);
  // clear on end of flag read or address change
  assign rd_clr  = rd_act_q && (addr_q == `WDK_OFF_CTRL_A) && (!rd_act || addr_s != addr_q);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] dog_period_low;
  logic [7:0] dog_period_high;
  logic [7:0] enable_and_steering_control;
  logic       osc_stop;
  logic       power_release;
  logic       prs;
  logic       dog_clr_en;

  logic time_transfer_enable;
  logic wake_power_enable;
  logic alarm_irq_enable;
  logic kick_irq_enable;
  logic dog_enable;
  logic dog_steer;

  assign time_transfer_enable = enable_and_steering_control[`WDK_BIT_TE];
  assign wake_power_enable    = enable_and_steering_control[`WDK_BIT_TPE];
  assign alarm_irq_enable     = enable_and_steering_control[`WDK_BIT_TIE];
  assign kick_irq_enable      = enable_and_steering_control[`WDK_BIT_KIE];
  assign dog_enable           = enable_and_steering_control[`WDK_BIT_WDE];
  assign dog_steer            = enable_and_steering_control[`WDK_BIT_WDS];

  // period value not promised to software; zero keeps the dog quiet
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dog_period_low  <= `WDK_PERIOD_RST;
      dog_period_high <= `WDK_PERIOD_RST;
    end else begin
      if (wr_lo) begin
        dog_period_low <= data_q;
      end
      if (wr_hi) begin
        dog_period_high <= data_q;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_and_steering_control <= `WDK_CTRL_B_RST;
    end else begin
      if (wr_b) begin
        enable_and_steering_control <= data_q;
      end
      // enable drops as reset pulse ends
      if (dog_clr_en) begin
        enable_and_steering_control[`WDK_BIT_WDE] <= 1'b0;
      end
    end
  end

  // oscillator runs only while stop bit is 0
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_stop <= 1'b0;
      osc_run  <= 1'b1;
    end else begin
      if (wr_m) begin
        osc_stop <= data_q[`WDK_BIT_OSC_STOP];
      end
      osc_run <= !osc_stop;
    end
  end

  // ----------------------------------------
  // Kick filter
  // ----------------------------------------
  logic [KW-1:0] kick_cnt;
  logic          kick_fall;

  // low must last the minimum kick pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      kick_cnt  <= '0;
      kick_fall <= 1'b0;
    end else if (kick_s) begin
      kick_cnt  <= '0;
      kick_fall <= 1'b0;
    end else if (kick_cnt == KW'(KC - 1)) begin
      kick_cnt  <= KW'(KC);
      kick_fall <= 1'b1;
    end else if (kick_cnt == KW'(KC)) begin
      kick_fall <= 1'b0;
    end else begin
      kick_cnt  <= kick_cnt + KW'(1);
      kick_fall <= 1'b0;
    end
  end

  // ----------------------------------------
  // Event qualification
  // ----------------------------------------
  logic batt_ok;
  logic wake_ok;
  logic alarm_set;
  logic kick_set;

  assign batt_ok   = osc_run && aux_s;
  assign wake_ok   = wake_power_enable && time_transfer_enable && batt_ok;
  // alarm wakes regardless of alarm enable
  assign alarm_set = alarm_hit && (supply_s || wake_ok);
  assign kick_set  = kick_fall && (supply_s || (kick_irq_enable && batt_ok));

  // ----------------------------------------
  // Watchdog timer
  // ----------------------------------------
  logic dog_tick;
  logic dog_expire;
  logic dog_load;

  // period write restarts the count
  // Delayed one edge: the period register only holds the new byte after the write edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dog_load <= 1'b0;
    end else begin
      dog_load <= wr_lo || wr_hi;
    end
  end

  // 10 ms tick from the clock
  wdk_tick_div #(
    .CYC     (TICK_CYC)
  ) u_tick (
    .clk     (clk),
    .rst_b   (rst_b),
    .run     (osc_run),
    .restart (dog_load),
    .tick    (dog_tick)
  );

  // four BCD digits, 0.01 s to 99.99 s
  wdk_bcd_down #(
    .DIGITS  (4)
  ) u_count (
    .clk     (clk),
    .rst_b   (rst_b),
    .period  ({dog_period_high, dog_period_low}),
    .load    (dog_load),
    .tick    (dog_tick),
    .expire  (dog_expire)
  );

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  logic alarm_match_flag;
  logic kick_flag;
  logic dog_timeout_flag;
  logic irq_request_flag;
  logic irq_src;

  // Hardware set wins over any clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_match_flag <= 1'b0;
    end else if (alarm_set) begin
      alarm_match_flag <= 1'b1;
    end else if (rd_clr || (wr_a && !data_q[`WDK_BIT_TDF])) begin
      alarm_match_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      kick_flag <= 1'b0;
    end else if (kick_set || (wr_a && data_q[`WDK_BIT_KSF])) begin
      kick_flag <= 1'b1;
    end else if (rd_clr || wr_a) begin
      kick_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dog_timeout_flag <= 1'b0;
    end else if (dog_expire) begin
      dog_timeout_flag <= 1'b1;
    end else if (rd_clr || (wr_a && !data_q[`WDK_BIT_WDF])) begin
      dog_timeout_flag <= 1'b0;
    end
  end

  assign irq_src = (alarm_match_flag && alarm_irq_enable)
                || (kick_flag && kick_irq_enable)
                || (dog_timeout_flag && dog_enable && !dog_steer);

  // kick flag drives the pin only when enabled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_request_flag <= 1'b0;
      irq_n            <= 1'b1;
    end else begin
      irq_request_flag <= irq_src;
      irq_n            <= !(irq_src && supply_s);
    end
  end

  // ----------------------------------------
  // Power request
  // ----------------------------------------
  // wake or kick clears the release, so the request pulls low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_release <= `WDK_PAB_RST;
      prs           <= `WDK_PRS_RST;
    end else begin
      if (wr_a) begin
        prs <= data_q[`WDK_BIT_PRS];
      end
      if ((alarm_match_flag && wake_power_enable && time_transfer_enable)
          || (kick_flag && kick_irq_enable)) begin
        power_release <= 1'b0;
      end else if (wr_a) begin
        power_release <= data_q[`WDK_BIT_PAB];
      end else if (supply_q && !supply_s && !prs) begin
        // Without hold-over the request lets go at power fail
        power_release <= 1'b1;
      end
    end
  end

  // Open drain: value always low, enable active low while pulling
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_on_request_n    <= 1'b0;
      power_on_request_oe_b <= 1'b1;
    end else begin
      power_on_request_n    <= 1'b0;
      power_on_request_oe_b <= power_release;
    end
  end

  // ----------------------------------------
  // Reset pulse sequencer
  // ----------------------------------------
  wdk_pkg::wdk_pulse_state_t state;
  logic [RW-1:0]             pulse_cnt;

  // steering 1 gives one low pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= wdk_pkg::WDK_PULSE_IDLE;
      pulse_cnt  <= '0;
      rst_out_n  <= 1'b1;
      dog_clr_en <= 1'b0;
    end else begin
      dog_clr_en <= 1'b0;
      case (state)
        wdk_pkg::WDK_PULSE_IDLE: begin
          if (dog_expire && dog_enable && dog_steer) begin
            state     <= wdk_pkg::WDK_PULSE_LOW;
            pulse_cnt <= '0;
            rst_out_n <= 1'b0;
          end
        end
        wdk_pkg::WDK_PULSE_LOW: begin
          if (pulse_cnt == RW'(RC - 1)) begin
            state      <= wdk_pkg::WDK_PULSE_IDLE;
            rst_out_n  <= 1'b1;
            dog_clr_en <= 1'b1;
          end else begin
            pulse_cnt <= pulse_cnt + RW'(1);
          end
        end
        default: begin
          state     <= wdk_pkg::WDK_PULSE_IDLE;
          rst_out_n <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (addr_s == `WDK_OFF_DOG_LO) begin
      next_rdata = dog_period_low;
    end else if (addr_s == `WDK_OFF_DOG_HI) begin
      next_rdata = dog_period_high;
    end else if (addr_s == `WDK_OFF_CTRL_A) begin
      next_rdata = {2'b00, prs, power_release, alarm_match_flag, kick_flag,
                    dog_timeout_flag, irq_request_flag};
    end else if (addr_s == `WDK_OFF_CTRL_B) begin
      next_rdata = enable_and_steering_control;
    end else if (addr_s == `WDK_OFF_MONTH) begin
      next_rdata = {osc_stop, 7'h00};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_data_out  <= 8'h00;
      bus_data_oe_b <= 1'b1;
    end else begin
      bus_data_out  <= next_rdata;
      bus_data_oe_b <= !rd_act;
    end
  end

endmodule : wdk_watchdog_wakeup

`default_nettype wire

/* File: verification/watchdog_wakeup_kickstart_tb.sv */
`default_nettype none

module watchdog_wakeup_kickstart_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst_b, bus_cs_b, bus_oe_b, bus_we_b, bus_data_oe_b, bench_on;
  logic       aux_battery, kick_input_n, alarm_hit, irq_n, rst_out_n, osc_run;
  logic       power_on_request_n, power_on_request_oe_b, system_supply, pwr_wire;
  logic [4:0] bus_addr;
  logic [7:0] bus_data_in, bus_data_out;
  int         failures, check_count, i;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  wdk_watchdog_wakeup #(.TICK_CYC(20), .RST_CYC(6), .KICK_CYC(3)) u_wdk_watchdog_wakeup (
    .clk, .rst_b, .bus_cs_b, .bus_oe_b, .bus_we_b, .bus_addr, .bus_data_in, .bus_data_out,
    .bus_data_oe_b, .system_supply, .aux_battery, .kick_input_n, .alarm_hit, .irq_n,
    .rst_out_n, .power_on_request_n, .power_on_request_oe_b, .osc_run);
  wdk_supply_model u_wdk_supply_model (.clk, .bench_on, .pwr_n(power_on_request_n),
    .pwr_oe_b(power_on_request_oe_b), .pwr_wire, .supply(system_supply));

  // ----------------------------------------
  // Bus and pin tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus_cs_b    = 1'b0;
    bus_we_b    = 1'b0;
    bus_addr    = a;
    bus_data_in = d;
    tick(3);
    bus_cs_b = 1'b1;
    bus_we_b = 1'b1;
    tick(6);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
    bus_cs_b = 1'b0;
    bus_oe_b = 1'b0;
    bus_addr = a;
    tick(4);
    chk(nm, bus_data_out, e);
    chk({nm, " oe on"}, 8'(bus_data_oe_b), 8'h00);
    bus_cs_b = 1'b1;
    bus_oe_b = 1'b1;
    tick(6);
    chk({nm, " oe off"}, 8'(bus_data_oe_b), 8'h01);
  endtask : rd

  task automatic kick();
    kick_input_n = 1'b0;
    tick(6);
    kick_input_n = 1'b1;
    tick(8);
  endtask : kick

  task automatic hit();
    alarm_hit = 1'b1;
    tick(1);
    alarm_hit = 1'b0;
    tick(6);
  endtask : hit

  // Power released, so the switch drops once bench supply goes
  task automatic sleep(input logic [7:0] c);
    wr(5'h0f, c);
    wr(5'h0e, 8'h10);
    bench_on = 1'b0;
    tick(10);
  endtask : sleep

  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst_b, alarm_hit, bus_addr, bus_data_in} = '0;
    {bus_cs_b, bus_oe_b, bus_we_b, bench_on, aux_battery, kick_input_n} = '1;
    failures    = 0;
    check_count = 0;
    tick(4);
    rst_b = 1'b1;
    tick(3);
    rd(5'h0f, 8'h00, "ctrl_b reset");
    rd(5'h1f, 8'h00, "unmapped");
    wr(5'h05, 8'h80);
    chk("osc stopped", 8'(osc_run), 8'h00);
    wr(5'h05, 8'h00);
    chk("osc running", 8'(osc_run), 8'h01);
    $display("test reset_osc done");
    wr(5'h0f, 8'h00);
    wr(5'h0d, 8'h00);
    wr(5'h0c, 8'h02);
    tick(60);
    chk("irq wde off", 8'(irq_n), 8'h01);
    wr(5'h0c, 8'h00);
    rd(5'h0e, 8'h02, "wdf wde off");
    tick(100);
    rd(5'h0e, 8'h00, "zero period");
    wr(5'h0f, 8'h02);
    for (i = 0; i < 6; i++) begin
      wr(5'h0c, 8'h02);
      tick(14);
    end
    chk("irq serviced", 8'(irq_n), 8'h01);
    for (i = 0; i < 100 && irq_n !== 1'b0; i++) tick(1);
    chk("irq repetitive", 8'(irq_n), 8'h00);
    wr(5'h0e, 8'h00);
    chk("irq wdf written", 8'(irq_n), 8'h01);
    for (i = 0; i < 100 && irq_n !== 1'b0; i++) tick(1);
    chk("irq reload", 8'(irq_n), 8'h00);
    wr(5'h0c, 8'h00);
    rd(5'h0e, 8'h03, "flags repetitive");
    chk("irq read clear", 8'(irq_n), 8'h01);
    wr(5'h0f, 8'h03);
    wr(5'h0c, 8'h02);
    for (i = 0; i < 100 && rst_out_n !== 1'b0; i++) tick(1);
    for (i = 0; i < 50 && rst_out_n === 1'b0; i++) tick(1);
    chk("reset pulse", 8'(i), 8'h06);
    chk("irq single", 8'(irq_n), 8'h01);
    wr(5'h0c, 8'h00);
    rd(5'h0f, 8'h01, "wde cleared");
    wr(5'h0e, 8'h00);
    $display("test watchdog done");
    wr(5'h0f, 8'h04);
    wr(5'h0e, 8'h10);
    chk("pwr released", 8'(pwr_wire), 8'h01);
    kick();
    chk("irq kick", 8'(irq_n), 8'h00);
    chk("pwr kick", 8'(pwr_wire), 8'h00);
    rd(5'h0e, 8'h05, "flags kick");
    chk("irq cleared", 8'(irq_n), 8'h01);
    wr(5'h0f, 8'h00);
    wr(5'h0e, 8'h10);
    kick();
    chk("irq kie off", 8'(irq_n), 8'h01);
    chk("pwr kie off", 8'(pwr_wire), 8'h01);
    wr(5'h0e, 8'h00);
    hit();
    chk("irq tie off", 8'(irq_n), 8'h01);
    wr(5'h0f, 8'h08);
    chk("irq tie on", 8'(irq_n), 8'h00);
    rd(5'h0e, 8'h09, "flags alarm");
    $display("test kick_alarm done");
    sleep(8'h04);
    kick();
    for (i = 0; i < 50 && irq_n !== 1'b0; i++) tick(1);
    chk("irq after wake", 8'(irq_n), 8'h00);
    bench_on = 1'b1;
    rd(5'h0e, 8'h05, "flags wake kick");
    sleep(8'h90);
    hit();
    for (i = 0; i < 50 && system_supply !== 1'b1; i++) tick(1);
    chk("alarm wake", 8'(system_supply), 8'h01);
    bench_on = 1'b1;
    rd(5'h0e, 8'h08, "flags wake alarm");
    sleep(8'h80);
    hit();
    tick(30);
    chk("no wake", 8'(system_supply), 8'h00);
    bench_on = 1'b1;
    $display("test wakeup done");
    finish_test();
  end
endmodule : watchdog_wakeup_kickstart_tb

`default_nettype wire

/* File: verification/wdk_supply_model.sv */
`default_nettype none

// ----------------------------------------
// System supply switch on the request pin
// ----------------------------------------
module wdk_supply_model #(
  parameter int unsigned DLY = 8
) (
  // Clock
  input  wire logic clk,
  // Bench-held supply
  input  wire logic bench_on,
  // Open-drain request pin
  input  wire logic pwr_n,
  input  wire logic pwr_oe_b,
  output logic      pwr_wire,
  // Supply to the device
  output logic      supply
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned low_cnt;

  // Pull-up takes the line high once released
  assign pwr_wire = pwr_oe_b ? 1'b1 : pwr_n;

  // Switch needs a settled request, drops as soon as released
  always_ff @(posedge clk) begin
    if (pwr_wire) begin
      low_cnt <= 0;
    end else if (low_cnt < DLY) begin
      low_cnt <= low_cnt + 1;
    end
  end
  assign supply = bench_on || (low_cnt == DLY);
endmodule : wdk_supply_model

`default_nettype wire

/* File: verification/wdk_watchdog_wakeup_assertions.sv */
`default_nettype none

// ----------------------------------------
// Pin-level checks
// ----------------------------------------
module wdk_watchdog_wakeup_chk #(
  parameter int unsigned RST_CYC = 25
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Inputs
  input wire logic bus_cs_b,
  input wire logic system_supply,
  input wire logic kick_input_n,
  input wire logic alarm_hit,
  // Outputs
  input wire logic irq_n,
  input wire logic rst_out_n,
  input wire logic power_on_request_n,
  input wire logic power_on_request_oe_b,
  input wire logic osc_run
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] bus_age, cause_age, clr_age, sup_age;
  logic [7:0] lo_cnt;
  logic       bus_seen;

  // Saturating age since last cause, so late effects stay bounded
  function automatic logic [4:0] age(input logic [4:0] v, input logic h);
    return h ? 5'h00 : v + {4'h0, v != 5'h1f};
  endfunction : age

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_age   <= 5'h00;
      cause_age <= 5'h00;
      clr_age   <= 5'h00;
      sup_age   <= 5'h00;
      lo_cnt    <= 8'h00;
      bus_seen  <= 1'b0;
    end else begin
      bus_age   <= age(bus_age, !bus_cs_b);
      cause_age <= age(cause_age, !bus_cs_b || !kick_input_n || alarm_hit);
      clr_age   <= age(clr_age, !bus_cs_b || !system_supply);
      sup_age   <= age(sup_age, system_supply);
      lo_cnt    <= rst_out_n ? 8'h00 : lo_cnt + 8'h01;
      bus_seen  <= !bus_cs_b || (bus_seen && rst_out_n);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  chk_irq_supply: assert property (
    !irq_n |-> sup_age < 5'h06) else $error("irq low without supply");
  chk_pulse_width: assert property (
    $rose(rst_out_n) |-> lo_cnt == 8'(RST_CYC)) else $error("reset pulse width");
  chk_single_pulse: assert property (
    $fell(rst_out_n) |-> bus_seen) else $error("reset pulse repeated");
  chk_osc_by_host: assert property (
    $changed(osc_run) |-> bus_age < 5'h10) else $error("osc changed alone");
  chk_pwr_cause: assert property (
    $fell(power_on_request_oe_b) |-> cause_age < 5'h10) else $error("pwr without cause");
  chk_irq_release: assert property (
    $rose(irq_n) |-> clr_age < 5'h10) else $error("irq cleared alone");
  chk_reset_idle: assert property (
    $rose(rst_b) |-> (rst_out_n && irq_n)[*8]) else $error("active after reset");
  chk_pwr_drive: assert property (
    power_on_request_n == 1'b0) else $error("pwr value not low");

  cover property ($fell(irq_n));
  cover property ($fell(rst_out_n));
  cover property ($fell(power_on_request_oe_b));
endmodule : wdk_watchdog_wakeup_chk

bind wdk_watchdog_wakeup wdk_watchdog_wakeup_chk #(.RST_CYC(RST_CYC)) u_chk (
  .clk, .rst_b, .bus_cs_b, .system_supply, .kick_input_n, .alarm_hit,
  .irq_n, .rst_out_n, .power_on_request_n, .power_on_request_oe_b, .osc_run);

`default_nettype wire
